// *** src/pcimo_core.sv ***
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module pcimo_core #(
	parameter logic [31:0] OPTIONS        = pcimo_pkg::OPT_DEFAULT,
	parameter bit          MASTER_CAPABLE = 1'b1,
	parameter int          DEPTH          = 16,
	// Arbitrary identity value returned by internal config dword zero.
	parameter logic [15:0] DEVICE_CODE    = 16'h5A5A
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        gntn,
	input  wire logic        trdyn,
	input  wire logic        stopn,
	input  wire logic        devseln,
	input  wire logic        ack64n,
	input  wire logic [63:0] ad_i,
	output logic      [63:0] ad_o,
	output logic             ad_oe,
	output logic      [7:0]  cben_o,
	output logic             ctl_oe,
	output logic             reqn,
	output logic             framen,
	output logic             irdyn,
	output logic             req64n,
	output logic             master_final_word_n
);

	localparam int IW = $clog2(DEPTH);

	// ============================================================
	// Elaboration-time options
	// ============================================================
	// Only the defined bits are looked at, so reserved bits cannot change behaviour.
	localparam logic [31:0] OPT = OPTIONS & pcimo_pkg::OPT_DEFINED_MASK;
	// Target-only builds get neither self-config nor timer behaviour.
	localparam bit SELFCFG_ON = MASTER_CAPABLE && OPT[pcimo_pkg::OPT_SELFCFG];
	localparam bit TIMER_OFF  = !MASTER_CAPABLE || OPT[pcimo_pkg::OPT_TIMER_OFF];
	localparam bit LEGACY     = OPT[pcimo_pkg::OPT_LEGACY];
	localparam bit WIDE_ONLY  = OPT[pcimo_pkg::OPT_WIDE_ONLY];
	localparam bit VARLANE    = OPT[pcimo_pkg::OPT_VARLANE];

	function automatic logic [31:0] half_data(input pcimo_pkg::pcimo_word_t w, input logic hi);
		half_data = hi ? w.data[63:32] : w.data[31:0];
	endfunction

	function automatic logic [3:0] half_lane(input pcimo_pkg::pcimo_word_t w, input logic hi);
		half_lane = hi ? w.lane_n[7:4] : w.lane_n[3:0];
	endfunction

	// ============================================================
	// Bus input synchronisers
	// ============================================================
	logic [68:0] sync1_r;
	logic [68:0] sync2_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= {5'h1F, 64'h0};
			sync2_r <= {5'h1F, 64'h0};
		end else begin
			sync1_r <= {gntn, trdyn, stopn, devseln, ack64n, ad_i};
			sync2_r <= sync1_r;
		end
	end
	wire        gnt_n_s    = sync2_r[68];
	wire        trdy_n_s   = sync2_r[67];
	wire        stop_n_s   = sync2_r[66];
	wire        devsel_n_s = sync2_r[65];
	wire        ack64_n_s  = sync2_r[64];
	wire [63:0] ad_s       = sync2_r[63:0];

	// ============================================================
	// Register state
	// ============================================================
	pcimo_pkg::pcimo_state_t st_r;
	pcimo_pkg::pcimo_word_t  mem [DEPTH];
	logic [3:0]    cmd_code_r;
	logic [IW-1:0] cnt_r;
	logic          narrow_r;
	logic          self_r;
	logic [31:0]   addr_r;
	logic [15:0]   cmdreg_r;
	logic [7:0]    lat_r;
	logic [IW-1:0] widx_r;
	logic [2:0]    term_r;
	logic [31:0]   prdata_r;
	logic          pready_r;
	logic          pslverr_r;
	logic [IW-1:0] ph_r;
	logic [7:0]    lt_r;
	logic [2:0]    dv_r;
	logic          wide_r;
	logic [7:0]    first_lane_r;
	logic [63:0]   ad_o_r;
	logic          ad_oe_r;
	logic [7:0]    cben_r;
	logic          ctl_oe_r;
	logic          reqn_r;
	logic          framen_r;
	logic          irdyn_r;
	logic          req64n_r;
	logic          final_n_r;

	// ============================================================
	// APB decode
	// ============================================================
	wire setup  = psel && !penable && !pready_r;
	wire commit = psel && penable && pready_r;
	wire wr     = commit && pwrite;
	wire idle   = (st_r == pcimo_pkg::ST_IDLE);

	wire hit_ctrl = (paddr == pcimo_pkg::REG_CTRL);
	wire hit_addr = (paddr == pcimo_pkg::REG_ADDR);
	wire hit_cmd  = (paddr == pcimo_pkg::REG_CMDREG);
	wire hit_lat  = (paddr == pcimo_pkg::REG_LATTMR);
	wire hit_stat = (paddr == pcimo_pkg::REG_STATUS);
	wire hit_opt  = (paddr == pcimo_pkg::REG_OPTIONS);
	wire hit_widx = (paddr == pcimo_pkg::REG_WIDX);
	wire hit_dlo  = (paddr == pcimo_pkg::REG_DATA_LO);
	wire hit_dhi  = (paddr == pcimo_pkg::REG_DATA_HI);
	wire hit_lane = (paddr == pcimo_pkg::REG_LANE);
	wire mapped   = hit_ctrl | hit_addr | hit_cmd | hit_lat | hit_stat | hit_opt |
	                hit_widx | hit_dlo | hit_dhi | hit_lane;

	// Master enable reads and acts as 1 when self-config is built in.
	wire        me_eff     = SELFCFG_ON ? 1'b1 : cmdreg_r[pcimo_pkg::CMDREG_ME];
	wire [15:0] cmd_view   = {cmdreg_r[15:3], me_eff, cmdreg_r[1:0]};
	wire [3:0]  wcmd       = pwdata[pcimo_pkg::CTRL_CMD_LSB +: 4];
	wire [IW-1:0] wcnt     = pwdata[pcimo_pkg::CTRL_CNT_LSB +: IW];
	wire        wself      = pwdata[pcimo_pkg::CTRL_SELF];
	wire        start      = wr && hit_ctrl && idle && MASTER_CAPABLE && me_eff && pwdata[pcimo_pkg::CTRL_START];
	wire        wcfg       = (wcmd == pcimo_pkg::CMD_CFG_RD) || (wcmd == pcimo_pkg::CMD_CFG_WR);
	// Self-directed config only goes internal when built in; otherwise it runs on the bus.
	wire        go_self    = SELFCFG_ON && wself && wcfg;
	wire        wmem       = (wcmd == pcimo_pkg::CMD_MEM_RD) || (wcmd == pcimo_pkg::CMD_MEM_WR);
	// Config, I/O and narrow requests never ask for 64 bits; a single phase only for wide-only writes.
	wire        wide_req   = !pwdata[pcimo_pkg::CTRL_NARROW] && wmem &&
	                         ((wcnt != '0) || (WIDE_ONLY && wcmd == pcimo_pkg::CMD_MEM_WR));

	wire [31:0] stat_view  = {25'h0, term_r, 3'h0, !idle};
	wire [31:0] rd_mux     = hit_ctrl ? {20'h0, 4'(cnt_r), cmd_code_r, 1'b0, self_r, narrow_r, 1'b0} :
	                         hit_addr ? addr_r :
	                         hit_cmd  ? {16'h0, cmd_view} :
	                         hit_lat  ? {24'h0, lat_r} :
	                         hit_stat ? stat_view :
	                         hit_opt  ? OPT :
	                         hit_widx ? 32'(widx_r) :
	                         hit_dlo  ? mem[widx_r].data[31:0] :
	                         hit_dhi  ? mem[widx_r].data[63:32] :
	                         hit_lane ? {24'h0, mem[widx_r].lane_n} : 32'h0;

	// ============================================================
	// Data phase selection
	// ============================================================
	wire          is_write  = cmd_code_r[0];
	wire          phase_wide = wide_r && !ack64_n_s;
	wire          xfer      = (st_r == pcimo_pkg::ST_DATA) && !trdy_n_s && !irdyn_r;
	wire [IW-1:0] ph_nxt    = xfer ? ph_r + 1'b1 : ph_r;
	// Legacy steering packs 32-bit phases into alternating halves of each stored word.
	wire          steer     = LEGACY && !phase_wide;
	wire [IW-1:0] sel_idx   = steer ? (ph_nxt >> 1) : ph_nxt;
	wire          sel_hi    = steer && (ph_nxt[0] ^ addr_r[2]);
	wire [IW-1:0] cap_idx   = steer ? (ph_r >> 1) : ph_r;
	wire          cap_hi    = steer && (ph_r[0] ^ addr_r[2]);
	wire pcimo_pkg::pcimo_word_t cur_w = mem[sel_idx];
	// Fixed lanes reuse the first word's enables; variable lanes follow each word.
	wire [7:0]    lane_src  = VARLANE ? cur_w.lane_n : first_lane_r;
	wire [63:0]   data_out  = phase_wide ? cur_w.data : {cur_w.data[63:32], half_data(cur_w, sel_hi)};
	wire [7:0]    lane_out  = phase_wide ? lane_src : {lane_src[7:4], VARLANE ? half_lane(cur_w, sel_hi) : lane_src[3:0]};
	// Timer expiry with grant gone forces the final phase; compiled out when the timer is off.
	wire          timer_kick = !TIMER_OFF && (lt_r == 8'h00) && gnt_n_s;

	// ============================================================
	// APB slave and software registers
	// ============================================================
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup && !mapped;
			if (setup) begin
				prdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_code_r <= 4'h0;
			cnt_r      <= '0;
			narrow_r   <= 1'b0;
			self_r     <= 1'b0;
			addr_r     <= 32'h0;
			lat_r      <= pcimo_pkg::LAT_RESET;
			widx_r     <= '0;
		end else if (wr && idle) begin
			if (hit_ctrl) begin
				cmd_code_r <= wcmd;
				cnt_r      <= wcnt;
				narrow_r   <= pwdata[pcimo_pkg::CTRL_NARROW];
				self_r     <= wself;
			end
			if (hit_addr) begin
				addr_r <= pwdata;
			end
			if (hit_lat) begin
				lat_r <= pwdata[7:0];
			end
			if (hit_widx) begin
				widx_r <= pwdata[IW-1:0];
			end
		end
	end

	// ============================================================
	// Master sequencer
	// ============================================================
	// Word storage is written here only, by software while idle, by captured bus reads and by internal config reads into word 0.
	always_ff @(posedge pclk) begin
		if (wr && idle && hit_dlo) begin
			mem[widx_r].data[31:0] <= pwdata;
		end
		if (wr && idle && hit_dhi) begin
			mem[widx_r].data[63:32] <= pwdata;
		end
		if (wr && idle && hit_lane) begin
			mem[widx_r].lane_n <= pwdata[7:0];
		end
		if (xfer && !is_write) begin
			if (phase_wide) begin
				mem[ph_r] <= '{data: ad_s, lane_n: cben_r};
			end else if (steer) begin
				if (cap_hi) begin
					mem[cap_idx].data[63:32] <= ad_s[31:0];
					mem[cap_idx].lane_n[7:4] <= cben_r[3:0];
				end else begin
					mem[cap_idx].data[31:0] <= ad_s[31:0];
					mem[cap_idx].lane_n[3:0] <= cben_r[3:0];
				end
			end else begin
				// Upper half carries nothing valid without steering.
				mem[ph_r] <= '{data: {32'h0, ad_s[31:0]}, lane_n: {4'hF, cben_r[3:0]}};
			end
		end
		if (st_r == pcimo_pkg::ST_SELF && !is_write) begin
			mem[0] <= '{data: {32'h0, (addr_r[7:2] == pcimo_pkg::CFG_CMD_DWORD) ? {16'h0, cmd_view} :
			             {DEVICE_CODE, 16'h0}}, lane_n: 8'h00};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= pcimo_pkg::ST_IDLE;
			cmdreg_r <= pcimo_pkg::CMDREG_RESET;
			term_r <= pcimo_pkg::TERM_NONE;
			{ph_r, lt_r, dv_r, wide_r, first_lane_r} <= '0;
			{ad_o_r, ad_oe_r, cben_r, ctl_oe_r} <= '0;
			{reqn_r, framen_r, irdyn_r, req64n_r, final_n_r} <= 5'h1F;
		end else begin
			if (wr && idle && hit_cmd) begin
				cmdreg_r <= pwdata[15:0];
			end
			if (lt_r != 8'h00) begin
				lt_r <= lt_r - 8'h01;
			end
			case (st_r)
			pcimo_pkg::ST_IDLE: begin
				ctl_oe_r <= 1'b0;
				ad_oe_r  <= 1'b0;
				if (start) begin
					st_r   <= go_self ? pcimo_pkg::ST_SELF : pcimo_pkg::ST_REQ;
					wide_r <= wide_req;
					term_r <= pcimo_pkg::TERM_NONE;
					ph_r   <= '0;
				end
			end
			pcimo_pkg::ST_SELF: begin
				// Internal config space reached without touching the bus.
				if (is_write && addr_r[7:2] == pcimo_pkg::CFG_CMD_DWORD) begin
					cmdreg_r <= mem[0].data[15:0];
				end
				term_r <= pcimo_pkg::TERM_DONE;
				st_r   <= pcimo_pkg::ST_IDLE;
			end
			pcimo_pkg::ST_REQ: begin
				reqn_r <= 1'b0;
				if (!gnt_n_s && !reqn_r) begin
					st_r     <= pcimo_pkg::ST_ADDR;
					lt_r     <= lat_r;
					ctl_oe_r <= 1'b1;
					ad_oe_r  <= 1'b1;
					framen_r <= 1'b0;
					req64n_r <= !wide_r;
					ad_o_r   <= {32'h0, addr_r};
					cben_r   <= {4'hF, cmd_code_r};
					first_lane_r <= mem[0].lane_n;
				end
			end
			pcimo_pkg::ST_ADDR, pcimo_pkg::ST_GAP: begin
				reqn_r  <= 1'b1;
				ad_oe_r <= is_write;
				ad_o_r  <= data_out;
				cben_r  <= lane_out;
				dv_r    <= 3'h0;
				// Wide-only wide requests skip the extra clock before irdyn.
				if (st_r == pcimo_pkg::ST_ADDR && !(WIDE_ONLY && wide_r)) begin
					st_r <= pcimo_pkg::ST_GAP;
				end else begin
					st_r      <= pcimo_pkg::ST_DATA;
					irdyn_r   <= 1'b0;
					framen_r  <= (cnt_r == '0);
					req64n_r  <= req64n_r | (cnt_r == '0);
					final_n_r <= !(cnt_r == '0);
				end
			end
			pcimo_pkg::ST_DATA: begin
				ad_o_r <= is_write ? data_out : ad_o_r;
				cben_r <= lane_out;
				dv_r   <= devsel_n_s ? dv_r + 3'h1 : 3'h0;
				if (!stop_n_s) begin
					// Target retry, disconnect or abort ends ownership in either timer mode.
					st_r   <= pcimo_pkg::ST_TURN;
					term_r <= devsel_n_s ? pcimo_pkg::TERM_TABORT : pcimo_pkg::TERM_STOP;
					framen_r <= 1'b1;
					req64n_r <= 1'b1;
				end else if (devsel_n_s && dv_r == pcimo_pkg::DEVSEL_LIMIT) begin
					st_r   <= pcimo_pkg::ST_TURN;
					term_r <= pcimo_pkg::TERM_MABORT;
					framen_r <= 1'b1;
					req64n_r <= 1'b1;
				end else if (xfer && framen_r) begin
					st_r <= pcimo_pkg::ST_TURN;
					term_r <= (ph_r == cnt_r) ? pcimo_pkg::TERM_DONE : pcimo_pkg::TERM_TIMER;
				end else begin
					ph_r <= ph_nxt;
					if ((xfer && ph_nxt == cnt_r) || timer_kick) begin
						framen_r  <= 1'b1;
						req64n_r  <= 1'b1;
						final_n_r <= 1'b0;
					end
				end
			end
			pcimo_pkg::ST_TURN: begin
				// Lines are driven high for one clock before release so the bus is not left floating low.
				st_r      <= pcimo_pkg::ST_IDLE;
				framen_r  <= 1'b1;
				irdyn_r   <= 1'b1;
				req64n_r  <= 1'b1;
				final_n_r <= 1'b1;
			end
			default: begin
				st_r <= pcimo_pkg::ST_IDLE;
			end
			endcase
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;
	assign ad_o    = ad_o_r;
	assign ad_oe   = ad_oe_r;
	assign cben_o  = cben_r;
	assign ctl_oe  = ctl_oe_r;
	assign reqn    = reqn_r;
	assign framen  = framen_r;
	assign irdyn   = irdyn_r;
	assign req64n  = req64n_r;
	assign master_final_word_n = final_n_r;

endmodule

// *** pkg/pcimo_pkg.sv ***
package pcimo_pkg;

	// ============================================================
	// Option vector bit positions and defaults
	// ============================================================
	localparam int          OPT_SELFCFG      = 13;
	localparam int          OPT_LEGACY       = 14;
	localparam int          OPT_TIMER_OFF    = 15;
	localparam int          OPT_WIDE_ONLY    = 16;
	localparam int          OPT_VARLANE      = 17;
	localparam logic [31:0] OPT_DEFAULT      = 32'h0000_8000;
	// Reserved bits 18 to 31 and the lower options handled elsewhere read back as zero.
	localparam logic [31:0] OPT_DEFINED_MASK = 32'h0003_E000;

	// ============================================================
	// Register byte offsets
	// ============================================================
	localparam logic [11:0] REG_CTRL    = 12'h000;
	localparam logic [11:0] REG_ADDR    = 12'h004;
	localparam logic [11:0] REG_CMDREG  = 12'h008;
	localparam logic [11:0] REG_LATTMR  = 12'h00C;
	localparam logic [11:0] REG_STATUS  = 12'h010;
	localparam logic [11:0] REG_OPTIONS = 12'h014;
	localparam logic [11:0] REG_WIDX    = 12'h018;
	localparam logic [11:0] REG_DATA_LO = 12'h01C;
	localparam logic [11:0] REG_DATA_HI = 12'h020;
	localparam logic [11:0] REG_LANE    = 12'h024;

	// ============================================================
	// Field positions and reset values
	// ============================================================
	localparam int          CTRL_START   = 0;
	localparam int          CTRL_NARROW  = 1;
	localparam int          CTRL_SELF    = 2;
	localparam int          CTRL_CMD_LSB = 4;
	localparam int          CTRL_CNT_LSB = 8;
	localparam int          CMDREG_ME    = 2;
	localparam int          STAT_TERM_LSB = 4;
	localparam logic [15:0] CMDREG_RESET = 16'h0000;
	localparam logic [7:0]  LAT_RESET    = 8'h00;
	localparam logic [2:0]  DEVSEL_LIMIT = 3'h5;
	localparam logic [5:0]  CFG_CMD_DWORD = 6'h01;

	// ============================================================
	// Bus commands and termination codes
	// ============================================================
	localparam logic [3:0] CMD_IO_RD  = 4'h2;
	localparam logic [3:0] CMD_IO_WR  = 4'h3;
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'hA;
	localparam logic [3:0] CMD_CFG_WR = 4'hB;

	localparam logic [2:0] TERM_NONE   = 3'h0;
	localparam logic [2:0] TERM_DONE   = 3'h1;
	localparam logic [2:0] TERM_STOP   = 3'h2;
	localparam logic [2:0] TERM_TABORT = 3'h3;
	localparam logic [2:0] TERM_MABORT = 3'h4;
	localparam logic [2:0] TERM_TIMER  = 3'h5;

	typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_ADDR, ST_GAP, ST_DATA, ST_TURN, ST_SELF} pcimo_state_t;

	typedef struct packed {
		logic [63:0] data;
		logic [7:0]  lane_n;
	} pcimo_word_t;

endpackage

// *** testbench/pcimo_checker.sv ***
`timescale 1ns/1ps
// ============================================================
// Port checker
// ============================================================
module pcimo_checker #(
	parameter logic [31:0] OPTIONS = pcimo_pkg::OPT_DEFAULT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic framen,
	input wire logic irdyn,
	input wire logic req64n,
	input wire logic ad_oe,
	input wire logic ctl_oe,
	input wire logic master_final_word_n
);
	logic wide_only;

	assign wide_only = OPTIONS[pcimo_pkg::OPT_WIDE_ONLY];

	default clocking dc @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_wide_gap: assert property ($fell(framen) && !req64n && wide_only |-> irdyn ##1 !irdyn)
		else $error("wide irdyn not one clock after framen");
	a_narrow_gap: assert property ($fell(framen) && (req64n || !wide_only) |-> irdyn[*2] ##1 !irdyn)
		else $error("irdyn not two clocks after framen");
	a_addr_drive: assert property ($fell(framen) |-> ctl_oe && ad_oe)
		else $error("address phase not driven");
	a_final_frame: assert property (!master_final_word_n && !irdyn |-> framen)
		else $error("framen low in final phase");
	a_turn_release: assert property ($rose(irdyn) |-> ctl_oe ##1 !ctl_oe && !ad_oe)
		else $error("bus not released after turnaround");
	a_wide_frame: assert property (!req64n |-> !framen)
		else $error("req64n low outside framen");

	c_wide: cover property ($fell(framen) && !req64n);
	c_err: cover property (pslverr);
	c_final: cover property (!master_final_word_n && !irdyn);
endmodule

bind pcimo_core pcimo_checker #(.OPTIONS(OPTIONS)) u_checker (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .framen, .irdyn, .req64n, .ad_oe, .ctl_oe, .master_final_word_n);

// *** testbench/pcimo_target.sv ***
`timescale 1ns/1ps
// ============================================================
// Arbiter and target standing for the rest of the bus
// ============================================================
module pcimo_target (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        reqn,
	input  wire logic        framen,
	input  wire logic        irdyn,
	input  wire logic        req64n,
	input  wire logic        ad_oe,
	input  wire logic [63:0] ad_o,
	input  wire logic        claim,
	input  wire logic        slow,
	input  wire logic        brief,
	output logic             gntn,
	output logic             trdyn,
	output logic             stopn,
	output logic             devseln,
	output logic             ack64n,
	output logic      [63:0] ad_i
);
	logic        active;
	logic        wide_r;
	logic        dly_r;
	logic [63:0] last_r;

	assign active = !framen || !irdyn;
	assign stopn  = 1'b1;
	// A released bus shows the inverse of its last value, so a stale sample cannot match.
	assign ad_i   = ad_oe ? ad_o : ~last_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gntn    <= 1'b1;
			trdyn   <= 1'b1;
			devseln <= 1'b1;
			ack64n  <= 1'b1;
			wide_r  <= 1'b0;
			dly_r   <= 1'b0;
			last_r  <= 64'h0;
		end else begin
			// Grant parks once requested; brief mode removes it while a transfer runs.
			gntn    <= (brief && !framen) || (reqn && gntn);
			devseln <= !(claim && active);
			wide_r  <= active && (wide_r || !req64n);
			ack64n  <= !(claim && active && (wide_r || !req64n));
			dly_r   <= !devseln;
			trdyn   <= !(claim && active && !devseln && (!slow || dly_r));
			last_r  <= ad_i;
		end
	end
endmodule

// *** testbench/pcimo_core_bench.sv ***
`timescale 1ns/1ps
// ============================================================
// Bench: wide-only, variable lanes, timer running
// ============================================================
module pcimo_core_bench;
	localparam logic [31:0] OPTS = 32'h0013_0000;
	logic        pclk = 1'b0;
	logic        presetn = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic [31:0] rv;
	logic        pready, pslverr, gntn, trdyn, stopn, devseln, ack64n, re;
	logic        ad_oe, ctl_oe, reqn, framen, irdyn, req64n, master_final_word_n, fr_r64;
	logic        fr_q = 1'b1;
	logic        claim = 1'b1;
	logic        slow = 1'b0;
	logic        brief = 1'b0;
	logic [63:0] ad_i, ad_o;
	logic [7:0]  cben_o, fr_cbe;
	logic [7:0]  lanes[$];
	logic [31:0] words[$];
	int          num_errors = 0;
	int          check_count = 0;

	always #2 pclk = ~pclk;

	pcimo_core #(.OPTIONS(OPTS)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .gntn, .trdyn, .stopn, .devseln, .ack64n, .ad_i, .ad_o, .ad_oe, .cben_o, .ctl_oe,
		.reqn, .framen, .irdyn, .req64n, .master_final_word_n);
	pcimo_target far (.pclk, .presetn, .reqn, .framen, .irdyn, .req64n, .ad_oe, .ad_o, .claim, .slow,
		.brief, .gntn, .trdyn, .stopn, .devseln, .ack64n, .ad_i);

	// Phases are logged only when the lane value differs from the last one logged, so data checks use changing lanes.
	always @(posedge pclk) begin
		fr_q <= framen;
		if (!framen && fr_q) begin
			fr_cbe <= cben_o;
			fr_r64 <= req64n;
		end
		if (!irdyn && !trdyn && (lanes.size() == 0 || lanes[$] !== cben_o)) begin
			lanes.push_back(cben_o);
			words.push_back(ad_o[31:0]);
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata;
		re = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rv);
	endtask

	task automatic wait_term(input logic [2:0] t);
		int n;
		n = 0;
		rv = 32'h0000_0001;
		while (rv[0] !== 1'b0 && n < 200) begin
			apb(1'b0, pcimo_pkg::REG_STATUS, 32'h0000_0000);
			n++;
		end
		chk("termination", {29'h0, t}, {29'h0, rv[6:4]});
	endtask

	task automatic put(input logic [3:0] i, input logic [31:0] lo, input logic [7:0] ln);
		apb(1'b1, pcimo_pkg::REG_WIDX, {28'h0, i});
		apb(1'b1, pcimo_pkg::REG_DATA_LO, lo);
		apb(1'b1, pcimo_pkg::REG_DATA_HI, ~lo);
		apb(1'b1, pcimo_pkg::REG_LANE, {24'h0, ln});
	endtask

	task automatic go(input logic [31:0] a, input logic [31:0] c);
		lanes.delete();
		words.delete();
		apb(1'b1, pcimo_pkg::REG_ADDR, a);
		apb(1'b1, pcimo_pkg::REG_CTRL, c);
	endtask

	task automatic t_regs;
		apb(1'b1, pcimo_pkg::REG_OPTIONS, 32'hFFFF_FFFF);
		rd_chk(pcimo_pkg::REG_OPTIONS, 32'h0003_0000, "options");
		rd_chk(pcimo_pkg::REG_CMDREG, 32'h0000_0000, "cmdreg");
		rd_chk(pcimo_pkg::REG_LATTMR, 32'h0000_0000, "lattmr");
		apb(1'b0, 12'hFFC, 32'h0000_0000);
		chk("unmapped error", 32'h0000_0001, {31'h0, re});
		apb(1'b1, pcimo_pkg::REG_CTRL, 32'h0000_0071);
		wait_term(3'h0);
	endtask

	task automatic t_cfg;
		apb(1'b1, pcimo_pkg::REG_CMDREG, 32'h0000_0004);
		put(4'h0, 32'h1234_5678, 8'hF0);
		go(32'h0000_0810, 32'h0000_00B3);
		wait_term(3'h1);
		chk("cfg command", 32'h0000_00FB, {24'h0, fr_cbe});
		chk("cfg narrow", 32'h0000_0001, {31'h0, fr_r64});
		chk("cfg data", 32'h1234_5678, words[0]);
		chk("cfg lanes", 32'h0000_0000, {28'h0, lanes[0][3:0]});
	endtask

	task automatic t_burst;
		logic [7:0] ln[3];
		ln = '{8'hF0, 8'h0F, 8'h00};
		for (int i = 0; i < 3; i++) put(4'(i), 32'hA000_0000 + 32'(i), ln[i]);
		go(32'h0000_1000, 32'h0000_0271);
		wait_term(3'h1);
		chk("burst wide", 32'h0000_0000, {31'h0, fr_r64});
		chk("burst phases", 32'h0000_0003, 32'(lanes.size()));
		for (int i = 0; i < 3; i++) begin
			chk("burst lanes", {24'h0, ln[i]}, {24'h0, lanes[i]});
			chk("burst data", 32'hA000_0000 + 32'(i), words[i]);
		end
	endtask

	task automatic t_single;
		go(32'h0000_2000, 32'h0000_0071);
		wait_term(3'h1);
		chk("single wide", 32'h0000_0000, {31'h0, fr_r64});
		chk("single data", 32'hA000_0000, words[0]);
	endtask

	task automatic t_timer;
		for (int i = 3; i < 16; i++) put(4'(i), 32'hB000_0000, 8'h00);
		apb(1'b1, pcimo_pkg::REG_LATTMR, 32'h0000_0002);
		brief <= 1'b1;
		slow  <= 1'b1;
		go(32'h0000_3000, 32'h0000_0F71);
		wait_term(3'h5);
		brief <= 1'b0;
	endtask

	task automatic t_read;
		for (int i = 0; i < 3; i++) put(4'(i), 32'hC000_0000, 8'h00);
		go(32'h0000_5000, 32'h0000_0261);
		wait_term(3'h1);
		chk("read lane changes", 32'h0000_0001, 32'(lanes.size()));
		chk("read lanes", 32'h0000_0000, {24'h0, lanes[0]});
	endtask

	task automatic t_abort;
		claim <= 1'b0;
		go(32'h0000_4000, 32'h0000_0073);
		wait_term(3'h4);
		claim <= 1'b1;
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		$display("unexpected watchdog: expected completion seen hang");
		end_of_test();
	end

	initial begin
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_cfg();
		t_burst();
		t_single();
		t_timer();
		t_read();
		t_abort();
		end_of_test();
	end
endmodule
